/* rtl/host_parallel_handshake_port.sv */
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "host_port_defines.svh"
// Operation
// - Adapter serves eight boards; a board answers only when select matches switches.
// - Handshake control lines are active high, except the shared attention line, which is active low.
// - Selected board captures the port byte and raises acknowledge in the same cycle.
// - Host drops request on acknowledge; board drops acknowledge after that.
// - Board readies byte, raises request, visible only while selected.
// - Host acknowledge enables board data; board drops request, drives while acknowledged.
// - Service request: code ready, interrupt flag when selected, attention pulled low.
// - Interrupt acknowledge clears attention latch; board drops its interrupt flag.
// - Selected abort strobe sets a latch raising a level 7 request.
// - Host-abort latch clears only by software access, never by itself.
// - Broadcast with reset or abort hits every board, ignoring select.
// - Host abort flip-flop sets on abort clock rise, cleared by clear select.
// - Attention latch sets with interrupt flag, holds until clear, drives line.
// - Level 7 request is OR of three abort sources, active low.
// - Halt indicator only when status code bits 3,1 low and 2,0 high.
// - Run indicators follow transfer-in-progress low and address strobe low.
// - Reset and abort buttons each have a set/reset debounce latch.
// - Attention clear on soft reset, or enabled, selected, interrupt acknowledge.
// - Host soft reset when enabled, reset asserted, selected or broadcast.
// - Host hard reset is soft reset decode plus interrupt acknowledge.
// - Soft sum: host, reset button, instruction; hard sum: host, both buttons.
module host_parallel_handshake_port
	import host_port_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int SEL_W = 3
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [SEL_W-1:0] i_board_select_addr,
	input wire logic [SEL_W-1:0] i_address_switch,
	input wire logic i_port_enable,
	input wire logic i_host_request,
	input wire logic i_host_acknowledge,
	input wire logic i_int_ack,
	input wire logic i_abort_strobe,
	input wire logic i_remote_reset,
	input wire logic i_broadcast_select,
	input wire logic [DATA_W-1:0] i_port_data,
	output logic [DATA_W-1:0] o_port_data,
	output logic o_port_data_oe,
	output logic o_board_acknowledge,
	output logic o_board_request,
	output logic o_board_interrupt_flag,
	output logic o_shared_attention_n,
	output logic o_shared_attention_oe,
	input wire logic i_reset_contact_a_n,
	input wire logic i_reset_contact_b_n,
	input wire logic i_abort_contact_a_n,
	input wire logic i_abort_contact_b_n,
	input wire logic i_reset_instruction_out_n,
	input wire logic i_breakpoint,
	input wire logic [3:0] i_cpu_status_code,
	input wire logic i_transfer_in_progress_n,
	input wire logic i_address_strobe_n,
	output logic o_host_soft_reset,
	output logic o_host_hard_reset,
	output logic o_soft_reset_sum,
	output logic o_hard_reset_sum,
	output logic o_level7_request_n,
	output logic o_cpu_run_led,
	output logic o_dma_run_led,
	output logic o_halt_led
);

	// The port byte must fit in one bus word.
	if (DATA_W < 1 || DATA_W > 32) begin : g_bad_data_w
		$error("DATA_W must lie between 1 and 32.");
	end
	if (SEL_W < 1 || SEL_W > 8) begin : g_bad_sel_w
		$error("SEL_W must lie between 1 and 8.");
	end

	logic selected_w;
	logic host_soft_w;
	logic host_hard_w;
	logic abort_clk_w;
	logic att_clear_n_w;
	logic reset_button_debounce;
	logic abort_button_debounce;

	host_cmd_decode #(.SEL_W(SEL_W)) u_decode (
		.i_board_select_addr(i_board_select_addr),
		.i_address_switch(i_address_switch),
		.i_port_enable(i_port_enable),
		.i_broadcast_select(i_broadcast_select),
		.i_remote_reset(i_remote_reset),
		.i_abort_strobe(i_abort_strobe),
		.i_int_ack(i_int_ack),
		.i_soft_reset_sum(o_soft_reset_sum),
		.o_selected(selected_w),
		.o_host_soft_reset(host_soft_w),
		.o_host_hard_reset(host_hard_w),
		.o_abort_clock(abort_clk_w),
		.o_attention_clear_n(att_clear_n_w)
	);

	// Button debouncers: one contact sets, the other clears.
	debounce_latch u_reset_deb (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.i_set(!i_reset_contact_a_n),
		.i_clear(!i_reset_contact_b_n),
		.o_level(reset_button_debounce)
	);
	debounce_latch u_abort_deb (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.i_set(!i_abort_contact_a_n),
		.i_clear(!i_abort_contact_b_n),
		.o_level(abort_button_debounce)
	);

	// Bus slave: every transfer takes one wait state, so read data
	// can come from a flop at no cost to the decode path.
	logic ahb_pend_reg;
	logic ahb_write_reg;
	logic [7:0] ahb_addr_reg;
	logic [31:0] rd_next;
	logic wr_now;
	logic rd_now;
	logic ahb_take;

	assign ahb_take = i_hsel && i_htrans[1] && i_hready;
	assign wr_now = i_clk_en && ahb_pend_reg && ahb_write_reg;
	assign rd_now = i_clk_en && ahb_pend_reg && !ahb_write_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ahb_pend_reg <= 1'b0;
			ahb_write_reg <= 1'b0;
			ahb_addr_reg <= `HP_RST_BYTE;
			o_hreadyout <= 1'b1;
			o_hrdata <= `HP_RST_WORD;
			o_hresp <= 1'b0;
		end else if (i_clk_en) begin
			if (ahb_pend_reg) begin
				ahb_pend_reg <= 1'b0;
				o_hreadyout <= 1'b1;
				o_hrdata <= ahb_write_reg ? `HP_RST_WORD : rd_next;
			end else if (ahb_take) begin
				ahb_pend_reg <= 1'b1;
				ahb_write_reg <= i_hwrite;
				ahb_addr_reg <= i_haddr[7:0];
				o_hreadyout <= 1'b0;
			end
		end
	end

	// Incoming byte handshake state.
	rx_state_t rx_state_reg;
	logic rx_valid_reg;
	logic [DATA_W-1:0] rx_data_reg;
	logic rx_capture;

	// A byte is only taken once the last one has been read, which holds
	// the host off instead of losing data.
	assign rx_capture = (rx_state_reg == RX_IDLE) && selected_w &&
		i_port_enable && i_host_request && !rx_valid_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rx_state_reg <= RX_IDLE;
			rx_data_reg <= '0;
			o_board_acknowledge <= 1'b0;
		end else if (i_clk_en) begin
			unique case (rx_state_reg)
				RX_IDLE: begin
					if (rx_capture) begin
						rx_data_reg <= i_port_data;
						o_board_acknowledge <= 1'b1;
						rx_state_reg <= RX_ACK;
					end
				end
				RX_ACK: begin
					if (!i_host_request) begin
						o_board_acknowledge <= 1'b0;
						rx_state_reg <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// Received flag: a capture wins over a read in the same cycle.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rx_valid_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (rx_capture) begin
				rx_valid_reg <= 1'b1;
			end else if (rd_now && ahb_addr_reg == `HP_OFF_RX_DATA) begin
				rx_valid_reg <= 1'b0;
			end
		end
	end

	// Outgoing transfer and service request sequencer.
	out_state_t out_state_reg;
	logic out_pending_reg;
	logic out_is_int_reg;
	logic [DATA_W-1:0] out_data_reg;
	logic out_busy;
	logic out_go;
	logic out_load;
	logic att_latch_reg;
	logic host_ack_sel;

	assign out_busy = out_pending_reg || (out_state_reg != OUT_IDLE);
	assign out_go = (out_state_reg == OUT_IDLE) && out_pending_reg &&
		!i_host_acknowledge && !i_int_ack;
	assign out_load = wr_now && !out_busy &&
		(ahb_addr_reg == `HP_OFF_TX_DATA ||
		ahb_addr_reg == `HP_OFF_SVC_CODE);
	assign host_ack_sel = selected_w && i_port_enable &&
		i_host_acknowledge;

	// Software loads a byte or service code; writes while busy are dropped.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			out_pending_reg <= 1'b0;
			out_is_int_reg <= 1'b0;
			out_data_reg <= '0;
		end else if (i_clk_en) begin
			if (out_load) begin
				out_pending_reg <= 1'b1;
				out_is_int_reg <= (ahb_addr_reg == `HP_OFF_SVC_CODE);
				out_data_reg <= i_hwdata[DATA_W-1:0];
			end else if (out_go) begin
				out_pending_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			out_state_reg <= OUT_IDLE;
		end else if (i_clk_en) begin
			unique case (out_state_reg)
				OUT_IDLE: begin
					if (out_go) begin
						out_state_reg <= OUT_REQ;
					end
				end
				OUT_REQ: begin
					if (host_ack_sel) begin
						out_state_reg <= OUT_DRIVE;
					end
				end
				OUT_DRIVE: begin
					if (!i_host_acknowledge) begin
						out_state_reg <= out_is_int_reg ?
							OUT_IACK : OUT_IDLE;
					end
				end
				OUT_IACK: begin
					if (!att_clear_n_w) begin
						out_state_reg <= OUT_END;
					end
				end
				OUT_END: begin
					if (!i_int_ack) begin
						out_state_reg <= OUT_IDLE;
					end
				end
			endcase
		end
	end

	// Port outputs gated by select so other boards see nothing, except the data byte, which only its enable guards.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_port_data <= '0;
			o_port_data_oe <= 1'b0;
			o_board_request <= 1'b0;
			o_board_interrupt_flag <= 1'b0;
		end else if (i_clk_en) begin
			o_port_data <= out_data_reg;
			o_port_data_oe <= host_ack_sel &&
				(out_state_reg == OUT_REQ ||
				out_state_reg == OUT_DRIVE);
			o_board_request <= !out_is_int_reg && selected_w &&
				(out_state_reg == OUT_REQ) && !host_ack_sel;
			o_board_interrupt_flag <= out_is_int_reg && selected_w &&
				(out_state_reg == OUT_REQ ||
				out_state_reg == OUT_DRIVE ||
				out_state_reg == OUT_IACK);
		end
	end

	// Attention latch pulls the shared line at once, selected or not.
	// A new request wins over a clear in the same cycle.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			att_latch_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (out_go && out_is_int_reg) begin
				att_latch_reg <= 1'b1;
			end else if (!att_clear_n_w) begin
				att_latch_reg <= 1'b0;
			end
		end
	end
	assign o_shared_attention_oe = att_latch_reg;

	// The open-collector level is always low when driven.
	always_ff @(posedge i_sys_clk) begin
		o_shared_attention_n <= 1'b0;
	end

	// Abort and breakpoint flip-flops, set on edges, cleared by software.
	logic abort_clk_q;
	logic abort_deb_q;
	logic breakpoint_q;
	logic host_abort_ff;
	logic abort_button_ff;
	logic breakpoint_ff;
	logic [2:0] clr_bits;

	assign clr_bits = (wr_now && ahb_addr_reg == `HP_OFF_LATCH_CLR) ?
		i_hwdata[2:0] : 3'h0;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			abort_clk_q <= 1'b0;
			abort_deb_q <= 1'b0;
			breakpoint_q <= 1'b0;
		end else if (i_clk_en) begin
			abort_clk_q <= abort_clk_w;
			abort_deb_q <= abort_button_debounce;
			breakpoint_q <= i_breakpoint;
		end
	end

	// No timeout here: only the clear select releases these.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			host_abort_ff <= 1'b0;
			abort_button_ff <= 1'b0;
			breakpoint_ff <= 1'b0;
		end else if (i_clk_en) begin
			if (abort_clk_w && !abort_clk_q) begin
				host_abort_ff <= 1'b1;
			end else if (clr_bits[`HP_CLR_HOST_ABORT]) begin
				host_abort_ff <= 1'b0;
			end
			if (abort_button_debounce && !abort_deb_q) begin
				abort_button_ff <= 1'b1;
			end else if (clr_bits[`HP_CLR_ABORT_BTN]) begin
				abort_button_ff <= 1'b0;
			end
			if (!i_breakpoint && breakpoint_q) begin
				breakpoint_ff <= 1'b1;
			end else if (clr_bits[`HP_CLR_BREAKPOINT]) begin
				breakpoint_ff <= 1'b0;
			end
		end
	end

	// Resets, level 7 request and indicators, registered as outputs.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_host_soft_reset <= 1'b0;
			o_host_hard_reset <= 1'b0;
			o_soft_reset_sum <= 1'b0;
			o_hard_reset_sum <= 1'b0;
			o_level7_request_n <= 1'b1;
			o_cpu_run_led <= 1'b0;
			o_dma_run_led <= 1'b0;
			o_halt_led <= 1'b0;
		end else if (i_clk_en) begin
			o_host_soft_reset <= host_soft_w;
			o_host_hard_reset <= host_hard_w;
			o_soft_reset_sum <= host_soft_w || (reset_button_debounce &&
				!abort_button_debounce) ||
				!i_reset_instruction_out_n;
			o_hard_reset_sum <= host_hard_w || (reset_button_debounce &&
				abort_button_debounce);
			o_level7_request_n <= !(abort_button_ff || host_abort_ff ||
				breakpoint_ff);
			o_cpu_run_led <= !i_transfer_in_progress_n;
			o_dma_run_led <= !i_address_strobe_n;
			o_halt_led <= (i_cpu_status_code == `HP_HALT_CODE);
		end
	end

	// Register read multiplexer; unmapped offsets read as zero.
	always_comb begin
		rd_next = `HP_RST_WORD;
		unique case (ahb_addr_reg)
			`HP_OFF_RX_DATA: rd_next[DATA_W-1:0] = rx_data_reg;
			`HP_OFF_STATUS: begin
				rd_next[`HP_ST_RX_VALID] = rx_valid_reg;
				rd_next[`HP_ST_OUT_BUSY] = out_busy;
				rd_next[`HP_ST_ATTENTION] = att_latch_reg;
				rd_next[`HP_ST_HOST_ABORT] = host_abort_ff;
				rd_next[`HP_ST_ABORT_BTN] = abort_button_ff;
				rd_next[`HP_ST_BREAKPOINT] = breakpoint_ff;
				rd_next[`HP_ST_SELECTED] = selected_w;
			end
			default: rd_next = `HP_RST_WORD;
		endcase
	end

	// Checks on the handshake and decode behaviour.
	a_ack_after_capture:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(o_board_acknowledge) |-> rx_valid_reg &&
		rx_data_reg == $past(i_port_data))
	else $error("Acknowledge rose without the captured byte.");

	a_ack_release:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_board_acknowledge && !i_host_request && i_clk_en
		|=> !o_board_acknowledge)
	else $error("Acknowledge held after request dropped.");

	a_request_gated:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_board_request && $past(i_clk_en) |-> $past(selected_w))
	else $error("Board request shown while not selected.");

	a_drive_window:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_port_data_oe && $past(i_clk_en) |->
		$past(i_host_acknowledge) && !o_board_request)
	else $error("Data driven without host acknowledge.");

	a_attention_pull:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_clk_en && out_go && out_is_int_reg |=> o_shared_attention_oe)
	else $error("Attention not pulled on service request.");

	a_abort_sticky:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		host_abort_ff && !clr_bits[`HP_CLR_HOST_ABORT] |=> host_abort_ff)
	else $error("Host abort latch released by itself.");

	a_abort_sets:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_clk_en && abort_clk_w && !abort_clk_q |=> ##1 !o_level7_request_n)
	else $error("Abort clock did not raise the level 7 request.");

	a_halt_decode:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$past(i_clk_en) |->
		o_halt_led == ($past(i_cpu_status_code) == 4'h5))
	else $error("Halt indicator does not follow the status code.");

	a_soft_reset:
	assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_clk_en && i_port_enable && i_remote_reset &&
		(selected_w || i_broadcast_select) |=> o_host_soft_reset)
	else $error("Host soft reset not raised.");

endmodule

/* pkg/host_port_defines.svh */
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// Register byte offsets on the bus slave, low address byte only.
`define HP_OFF_TX_DATA 8'h00
`define HP_OFF_RX_DATA 8'h04
`define HP_OFF_SVC_CODE 8'h08
`define HP_OFF_STATUS 8'h0C
`define HP_OFF_LATCH_CLR 8'h10

// Status register bit positions.
`define HP_ST_RX_VALID 0
`define HP_ST_OUT_BUSY 1
`define HP_ST_ATTENTION 2
`define HP_ST_HOST_ABORT 3
`define HP_ST_ABORT_BTN 4
`define HP_ST_BREAKPOINT 5
`define HP_ST_SELECTED 6

// Latch clear register bit positions.
`define HP_CLR_HOST_ABORT 0
`define HP_CLR_ABORT_BTN 1
`define HP_CLR_BREAKPOINT 2

// Reset values.
`define HP_RST_WORD 32'h00000000
`define HP_RST_BYTE 8'h00

// Status code that marks the halted processor.
`define HP_HALT_CODE 4'h5

// Least hold time of the remote reset line, and its cycle count.
`define HP_CLK_PERIOD_NS 40
`define HP_RESET_MIN_NS 26000
`define HP_RESET_MIN_CYC \
	((`HP_RESET_MIN_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)

`endif

/* pkg/host_port_pkg.sv */
package host_port_pkg;

	// Outgoing transfer and interrupt sequencer.
	typedef enum logic [4:0] {
		OUT_IDLE = 5'b00001,
		OUT_REQ = 5'b00010,
		OUT_DRIVE = 5'b00100,
		OUT_IACK = 5'b01000,
		OUT_END = 5'b10000
	} out_state_t;

	// Incoming byte handshake.
	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_ACK = 2'b10
	} rx_state_t;

endpackage

/* rtl/debounce_latch.sv */
`timescale 1ns/1ps

// Set/reset latch for a changeover push-button contact pair.
module debounce_latch (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic i_set,
	input wire logic i_clear,
	output logic o_level
);

	// Set wins, so a bouncing contact can only ever repeat the same level.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_level <= 1'b0;
		end else if (i_clk_en) begin
			if (i_set) begin
				o_level <= 1'b1;
			end else if (i_clear) begin
				o_level <= 1'b0;
			end
		end
	end

endmodule

/* rtl/host_cmd_decode.sv */
`timescale 1ns/1ps

// Combinational decode of the host command lines for this board.
module host_cmd_decode #(
	parameter int SEL_W = 3
) (
	input wire logic [SEL_W-1:0] i_board_select_addr,
	input wire logic [SEL_W-1:0] i_address_switch,
	input wire logic i_port_enable,
	input wire logic i_broadcast_select,
	input wire logic i_remote_reset,
	input wire logic i_abort_strobe,
	input wire logic i_int_ack,
	input wire logic i_soft_reset_sum,
	output logic o_selected,
	output logic o_host_soft_reset,
	output logic o_host_hard_reset,
	output logic o_abort_clock,
	output logic o_attention_clear_n
);

	logic hit;

	// Address match, and broadcast overriding the select value.
	assign o_selected = (i_board_select_addr == i_address_switch);
	assign hit = i_port_enable && (o_selected || i_broadcast_select);

	// Reset and abort commands.
	assign o_host_soft_reset = hit && i_remote_reset;
	assign o_host_hard_reset = hit && i_remote_reset && i_int_ack;
	assign o_abort_clock = hit && i_abort_strobe;

	// Attention clear, active low.
	assign o_attention_clear_n = !(i_soft_reset_sum ||
		(i_port_enable && o_selected && i_int_ack));

endmodule

/* verification/host_adapter_model.sv */
`timescale 1ns/1ps

// Host adapter side of the port, paced the way host software would pace it.
module host_adapter_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_board_data,
	input wire logic i_board_data_oe,
	input wire logic i_board_acknowledge,
	input wire logic i_board_request,
	input wire logic i_board_interrupt_flag,
	output logic [2:0] o_select,
	output logic o_request,
	output logic o_acknowledge,
	output logic o_int_ack,
	output logic [7:0] o_bus
);
	logic [7:0] latch_q;
	logic [7:0] float_q;

	// The host buffer only reaches the bus while its request is up.
	assign o_bus = i_board_data_oe ? i_board_data :
		(o_request ? latch_q : float_q);

	// A released bus keeps changing, so a stale byte can never pass.
	always @(posedge i_sys_clk) begin
		float_q <= ~o_bus;
	end

	// Lines start negated with the select pointing nowhere useful.
	initial begin
		o_select = 3'h0;
		o_request = 1'b0;
		o_acknowledge = 1'b0;
		o_int_ack = 1'b0;
		latch_q = 8'h00;
		float_q = 8'hA5;
	end

	// Select and interrupt acknowledge are set together, as software does.
	task automatic set_ctl(input logic [2:0] sel, input logic iack);
		o_select <= sel;
		o_int_ack <= iack;
		@(posedge i_sys_clk);
	endtask

	// Byte to the board: latch, request, wait acknowledge, then release.
	task automatic send_byte(input logic [7:0] b);
		latch_q <= b;
		@(posedge i_sys_clk);
		o_request <= 1'b1;
		do @(posedge i_sys_clk); while (i_board_acknowledge !== 1'b1);
		o_request <= 1'b0;
		do @(posedge i_sys_clk); while (i_board_acknowledge !== 1'b0);
	endtask

	// Byte from the board, for a data request or a service code alike.
	task automatic take_byte(output logic [7:0] b);
		while (i_board_request !== 1'b1 && i_board_interrupt_flag !== 1'b1)
			@(posedge i_sys_clk);
		o_acknowledge <= 1'b1;
		do @(posedge i_sys_clk); while (i_board_data_oe !== 1'b1);
		b = o_bus;
		o_acknowledge <= 1'b0;
		@(posedge i_sys_clk);
	endtask

	// Interrupt acknowledge is held until the board drops its flag.
	task automatic ack_int();
		o_int_ack <= 1'b1;
		do @(posedge i_sys_clk); while (i_board_interrupt_flag !== 1'b0);
		o_int_ack <= 1'b0;
		@(posedge i_sys_clk);
	endtask
endmodule

/* verification/host_parallel_handshake_port_bench.sv */
`timescale 1ns/1ps
`include "host_port_defines.svh"

module host_parallel_handshake_port_bench;
	logic sys_clk, rst, hsel, hwrite, port_enable, abort_strobe;
	logic remote_reset, broadcast, rst_a_n, rst_b_n, abt_a_n, abt_b_n;
	logic rsti_n, bkpt, xfer_n, as_n, hready, hresp, oe, back, breq, bflag;
	logic attn_n, attn_oe, hsr, hhr, ssum, hsum, l7_n, clk_en;
	logic led_cpu, led_dma, led_halt, hreq, hack, iack;
	logic [1:0] htrans;
	logic [2:0] sw, sel;
	logic [3:0] code;
	logic [7:0] port_out, port_bus, b, got;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;

	host_parallel_handshake_port i_dut (.i_sys_clk(sys_clk), .i_rst(rst),
		.i_clk_en(clk_en), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_board_select_addr(sel), .i_address_switch(sw),
		.i_port_enable(port_enable), .i_host_request(hreq),
		.i_host_acknowledge(hack), .i_int_ack(iack),
		.i_abort_strobe(abort_strobe), .i_remote_reset(remote_reset),
		.i_broadcast_select(broadcast), .i_port_data(port_bus),
		.o_port_data(port_out), .o_port_data_oe(oe),
		.o_board_acknowledge(back), .o_board_request(breq),
		.o_board_interrupt_flag(bflag), .o_shared_attention_n(attn_n),
		.o_shared_attention_oe(attn_oe), .i_reset_contact_a_n(rst_a_n),
		.i_reset_contact_b_n(rst_b_n), .i_abort_contact_a_n(abt_a_n),
		.i_abort_contact_b_n(abt_b_n), .i_reset_instruction_out_n(rsti_n),
		.i_breakpoint(bkpt), .i_cpu_status_code(code),
		.i_transfer_in_progress_n(xfer_n), .i_address_strobe_n(as_n),
		.o_host_soft_reset(hsr), .o_host_hard_reset(hhr),
		.o_soft_reset_sum(ssum), .o_hard_reset_sum(hsum),
		.o_level7_request_n(l7_n), .o_cpu_run_led(led_cpu),
		.o_dma_run_led(led_dma), .o_halt_led(led_halt));

	host_adapter_model i_host (.i_sys_clk(sys_clk), .i_board_data(port_out),
		.i_board_data_oe(oe), .i_board_acknowledge(back),
		.i_board_request(breq), .i_board_interrupt_flag(bflag),
		.o_select(sel), .o_request(hreq), .o_acknowledge(hack),
		.o_int_ack(iack), .o_bus(port_bus));

	// Free-running system clock at 25 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// A hang anywhere ends the run as a failure.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Single word transfer; waits on the slave's ready in both phases.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	// Halted when status bits 3 and 1 are low and bits 2 and 0 are high.
	function automatic logic halt_exp(input logic [3:0] c);
		return !c[3] && c[2] && !c[1] && c[0];
	endfunction

	// Main sequence: reset, then each group of behaviour in turn.
	initial begin
		rst = 1'b1;
		{hsel, hwrite, abort_strobe, remote_reset, broadcast} = 5'h00;
		{htrans, haddr, hwdata} = 66'h0;
		{port_enable, rst_a_n, rst_b_n, abt_a_n, abt_b_n} = 5'b11010;
		{rsti_n, bkpt, xfer_n, as_n, code} = 8'hF0;
		sw = 3'h5;
		clk_en = 1'b1;
		rd = $urandom(32'hD3987812);
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk({l7_n, breq, back, hready, hresp}, 5'b10010);
		i_host.set_ctl(3'h5, 1'b0);
		repeat (4) begin
			b = 8'($urandom());
			i_host.send_byte(b);
			chk(back, 1'b0);
			bus(1'b0, `HP_OFF_RX_DATA, 32'h0, rd);
			chk(rd, {24'h000000, b});
		end
		repeat (3) begin
			b = 8'($urandom());
			bus(1'b1, `HP_OFF_TX_DATA, {24'h000000, b}, rd);
			i_host.set_ctl(3'h2, 1'b0);
			tick(4);
			chk(breq, 1'b0);
			i_host.set_ctl(3'h5, 1'b0);
			i_host.take_byte(got);
			chk(got, b);
			tick(3);
			chk({oe, breq}, 2'b00);
		end
		b = 8'($urandom());
		bus(1'b1, `HP_OFF_SVC_CODE, {24'h000000, b}, rd);
		tick(3);
		chk({attn_oe, attn_n}, 2'b10);
		i_host.take_byte(got);
		chk(got, b);
		i_host.ack_int();
		tick(3);
		chk({attn_oe, bflag}, 2'b00);
		bus(1'b0, `HP_OFF_STATUS, 32'h0, rd);
		chk(rd[`HP_ST_OUT_BUSY], 1'b0);
		bus(1'b1, 8'h20, 32'hFFFFFFFF, rd);
		bus(1'b0, 8'h20, 32'h0, rd);
		chk(rd, 32'h00000000);
		i_host.set_ctl(3'h2, 1'b0);
		abort_strobe <= 1'b1;
		tick(3);
		abort_strobe <= 1'b0;
		tick(3);
		chk(l7_n, 1'b1);
		for (int k = 0; k < 3; k++) begin
			broadcast <= (k == 0);
			abort_strobe <= (k == 0);
			abt_a_n <= (k != 1);
			abt_b_n <= (k == 1);
			bkpt <= (k != 2);
			tick(2);
			{broadcast, abort_strobe, abt_a_n, abt_b_n, bkpt} <= 5'b00101;
			tick(40);
			chk(l7_n, 1'b0);
			bus(1'b0, `HP_OFF_STATUS, 32'h0, rd);
			chk(rd[`HP_ST_HOST_ABORT + k], 1'b1);
			bus(1'b1, `HP_OFF_LATCH_CLR, 32'h1 << k, rd);
			tick(3);
			chk(l7_n, 1'b1);
		end
		for (int k = 0; k < 4; k++) begin
			i_host.set_ctl(k[0] ? 3'h5 : 3'h1, k[1]);
			remote_reset <= 1'b1;
			tick(3);
			chk({hsr, ssum}, {2{k[0]}});
			chk({hhr, hsum}, {2{k[0] & k[1]}});
			remote_reset <= 1'b0;
			i_host.set_ctl(3'h5, 1'b0);
			tick(3);
		end
		{rst_a_n, rst_b_n} <= 2'b01;
		tick(3);
		chk({ssum, hsum}, 2'b10);
		{abt_a_n, abt_b_n} <= 2'b01;
		tick(3);
		chk({ssum, hsum}, 2'b01);
		{rst_a_n, rst_b_n, abt_a_n, abt_b_n, rsti_n} <= 5'b10100;
		tick(3);
		chk({ssum, hsum}, 2'b10);
		rsti_n <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			code <= 4'(k);
			xfer_n <= 1'($urandom());
			as_n <= 1'($urandom());
			tick(3);
			chk(led_halt, halt_exp(4'(k)));
			chk({led_cpu, led_dma}, {~xfer_n, ~as_n});
		end
		// With the enable low the indicator must keep its old level.
		clk_en <= 1'b0;
		code <= `HP_HALT_CODE;
		tick(3);
		chk(led_halt, halt_exp(4'hF));
		clk_en <= 1'b1;
		tick(3);
		chk(led_halt, halt_exp(`HP_HALT_CODE));
		wrap_up();
	end
endmodule
